// ---- hw/pmc_pkg.sv ----
package pmc_pkg;
    // power control register layout
    localparam int PWR_IDLE_BIT = 0;
    localparam int PWR_STOP_BIT = 1;
    localparam int PWR_GF_LSB = 2;
    localparam logic [7:0] PWR_RESET = 8'h00;
    // internal oscillator control: suspend trigger
    localparam int OSC_SUSPEND_BIT = 5;
    // restart address after any reset
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    // system clock and missing-clock timeout
    localparam int CLK_HZ = 20_000_000;
    localparam int CLKMON_TIMEOUT_US = 100;
    localparam int CLKMON_TIMEOUT_CYC = (CLKMON_TIMEOUT_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                        CLKMON_TIMEOUT_US * (CLK_HZ / 1_000_000);
    // cycles the core is held in reset before fetch restarts
    localparam int RESET_HOLD_CYC = 4;

    typedef enum logic [3:0] {
        PMC_RUN = 4'b0001,
        PMC_IDLE = 4'b0010,
        PMC_STOP = 4'b0100,
        PMC_SUSP = 4'b1000
    } pmc_mode_e;

    // enables handed to the rest of the chip
    typedef struct packed {
        logic cpu_clk;
        logic int_osc;
        logic dig_periph;
        logic irq_timers;
        logic port_match;
    } pmc_gate_s;
endpackage

// ---- hw/pmc_expiry_timer.sv ----
`timescale 1ns/100ps
module pmc_expiry_timer
    import pmc_pkg::*;
#(
    parameter int COUNT = CLKMON_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control
    input wire logic i_run,
    // status
    output logic o_expired
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

    logic [CW-1:0] cnt_reg;

    // a zero count would never expire
    if (COUNT < 1) begin : g_bad_count
        $error("pmc_expiry_timer: COUNT must be at least 1");
    end

    // counts while armed; any gap restarts the timeout from zero
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= '0;
            o_expired <= 1'b0;
        end else if (!i_run) begin
            cnt_reg <= '0;
            o_expired <= 1'b0;
        end else begin
            o_expired <= (cnt_reg == LAST);
            cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
        end
    end
endmodule

// ---- hw/pmc_power_mode_ctrl.sv ----
// Notes on behaviour
// (R1) idle select write halts cpu into Idle once the writing instruction completes
// (R2) Idle keeps register state and all clocks and peripherals running; here the cpu clock is gated off in Idle
// (R3) Idle ends on enabled interrupt or reset; interrupt clears idle select, cpu resumes
// (R4) after interrupt wake, pending interrupt serviced, then next instruction continues
// (R5) reset ending any low-power state runs reset sequence, fetch from 0x0000
// (R6) software follows idle write with an instruction of two or more bytes
// (R7) enabled watchdog expiry in Idle raises internal reset ending Idle
// (R8) stop select write enters Stop: internal osc, cpu, digital peripherals halt
// (R9) in Stop only missing-clock detector runs; analog keeps software state
// (R10) Stop ends only on reset; interrupts never end Stop
// (R11) enabled missing-clock detector resets out of Stop after 100 us
// (R12) suspend bit write halts cpu and internal osc, keeping state
// (R13) in Suspend only port-match logic stays active
// (R14) Suspend ends on port match, enabled comparator low, or reset
// (R15) non-reset Suspend wake resumes at next instruction, wake interrupt serviced
// (R16) firmware sets reference bias enable when entering Suspend
// (R17) idle and stop select self-clear and always read as zero
// (R18) both selects written together enter Stop
`timescale 1ns/100ps
module pmc_power_mode_ctrl
    import pmc_pkg::*;
#(
    parameter int HOLD_CYC = RESET_HOLD_CYC,
    parameter int CLKMON_CYC = CLKMON_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register writes from the core
    input wire logic i_pwr_wr,
    input wire logic [7:0] i_pwr_wdata,
    input wire logic i_osc_wr,
    input wire logic [7:0] i_osc_wdata,
    input wire logic i_instr_done,
    // wake and reset sources
    input wire logic i_irq_pending,
    input wire logic i_ext_rst_n,
    input wire logic i_wdog_en,
    input wire logic i_wdog_expire,
    input wire logic i_clkmon_en,
    input wire logic i_port_match,
    input wire logic i_cmp_low,
    input wire logic i_cmp_wake_en,
    input wire logic i_wake_irq_en,
    // status and control out
    output logic [7:0] o_pwr_rdata,
    output pmc_mode_e o_mode,
    output pmc_gate_s o_gate,
    output logic o_core_rst,
    output logic o_fetch_load,
    output logic [15:0] o_fetch_addr,
    output logic o_resume,
    output logic o_wake_irq
);
    localparam int HW = $clog2(HOLD_CYC + 1);

    pmc_mode_e state_reg, state_next;
    logic idle_arm_reg, stop_arm_reg, susp_arm_reg;
    logic [5:0] gf_reg;
    logic [HW-1:0] hold_reg;
    logic ext_s1_reg, ext_s2_reg, pm_s1_reg, pm_s2_reg, cmp_s1_reg, cmp_s2_reg;
    logic clkmon_expired, rst_req, susp_wake, idle_wake;

    // a zero hold would never raise the fetch pulse
    if (HOLD_CYC < 1) begin : g_bad_hold
        $error("pmc_power_mode_ctrl: HOLD_CYC must be at least 1");
    end

    // pins cross in through two flops; reset pin is active low
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ext_s1_reg <= 1'b1;
            ext_s2_reg <= 1'b1;
            pm_s1_reg <= 1'b0;
            pm_s2_reg <= 1'b0;
            cmp_s1_reg <= 1'b0;
            cmp_s2_reg <= 1'b0;
        end else begin
            ext_s1_reg <= i_ext_rst_n;
            ext_s2_reg <= ext_s1_reg;
            pm_s1_reg <= i_port_match;
            pm_s2_reg <= pm_s1_reg;
            cmp_s1_reg <= i_cmp_low;
            cmp_s2_reg <= cmp_s1_reg;
        end
    end

    // (R11) missing clock timeout
    pmc_expiry_timer #(
        .COUNT(CLKMON_CYC)
    ) u_clkmon (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_run(i_clkmon_en && state_reg == PMC_STOP),
        .o_expired(clkmon_expired)
    );

    // (R7) watchdog reset only while its clock runs, never in Stop or Suspend
    assign rst_req = !ext_s2_reg || clkmon_expired ||
                     (i_wdog_en && i_wdog_expire && (state_reg == PMC_RUN || state_reg == PMC_IDLE));
    // (R3) enabled interrupt wakes Idle
    assign idle_wake = (state_reg == PMC_IDLE) && i_irq_pending;
    // (R14) suspend wake sources
    assign susp_wake = (state_reg == PMC_SUSP) && (pm_s2_reg || (cmp_s2_reg && i_cmp_wake_en));

    // mode transitions; reset requests beat every other event
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PMC_RUN: begin
                // (R18) stop beats idle
                if (i_instr_done && stop_arm_reg) begin
                    state_next = PMC_STOP;
                end else if (i_instr_done && idle_arm_reg) begin
                    state_next = PMC_IDLE;
                end else if (i_instr_done && susp_arm_reg) begin
                    state_next = PMC_SUSP;
                end
            end
            PMC_IDLE: begin
                if (idle_wake) begin
                    state_next = PMC_RUN;
                end
            end
            // (R10) no interrupt leaves Stop
            PMC_STOP: state_next = PMC_STOP;
            PMC_SUSP: begin
                if (susp_wake) begin
                    state_next = PMC_RUN;
                end
            end
            default: state_next = PMC_RUN;
        endcase
        if (rst_req || hold_reg != '0) begin
            state_next = PMC_RUN;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= PMC_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // (R1) trigger arms on write, fires when the writing instruction retires
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            idle_arm_reg <= 1'b0;
            stop_arm_reg <= 1'b0;
            susp_arm_reg <= 1'b0;
        end else if (rst_req || state_next != PMC_RUN) begin
            idle_arm_reg <= 1'b0;
            stop_arm_reg <= 1'b0;
            susp_arm_reg <= 1'b0;
        end else begin
            if (i_pwr_wr) begin
                idle_arm_reg <= i_pwr_wdata[PWR_IDLE_BIT];
                stop_arm_reg <= i_pwr_wdata[PWR_STOP_BIT];
            end
            if (i_osc_wr) begin
                susp_arm_reg <= i_osc_wdata[OSC_SUSPEND_BIT];
            end
        end
    end

    // (R17) general flags stored; select bits always read zero
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gf_reg <= PWR_RESET[7:PWR_GF_LSB];
            o_pwr_rdata <= PWR_RESET;
        end else begin
            if (i_pwr_wr) begin
                gf_reg <= i_pwr_wdata[7:PWR_GF_LSB];
            end
            o_pwr_rdata <= {(i_pwr_wr ? i_pwr_wdata[7:PWR_GF_LSB] : gf_reg), 2'b00};
        end
    end

    // (R5) hold core in reset, then restart fetch at the vector
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_reg <= HW'(HOLD_CYC);
            o_core_rst <= 1'b1;
            o_fetch_load <= 1'b0;
            o_fetch_addr <= RESET_VECTOR;
        end else begin
            o_fetch_addr <= RESET_VECTOR;
            if (rst_req) begin
                hold_reg <= HW'(HOLD_CYC);
                o_core_rst <= 1'b1;
                o_fetch_load <= 1'b0;
            end else begin
                hold_reg <= (hold_reg != '0) ? hold_reg - 1'b1 : hold_reg;
                o_core_rst <= (hold_reg > HW'(1));
                o_fetch_load <= (hold_reg == HW'(1));
            end
        end
    end

    // (R4) resume continues after the entry instruction; core services the interrupt
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_resume <= 1'b0;
            o_wake_irq <= 1'b0;
        end else begin
            // (R15) suspend wake resumes, optionally with interrupt
            o_resume <= !rst_req && (idle_wake || susp_wake);
            o_wake_irq <= !rst_req && susp_wake && i_wake_irq_en;
        end
    end

    // clock and peripheral gates follow the next mode so they settle with it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mode <= PMC_RUN;
            o_gate <= '{cpu_clk: 1'b1, int_osc: 1'b1, dig_periph: 1'b1, irq_timers: 1'b1, port_match: 1'b1};
        end else begin
            o_mode <= state_next;
            // (R2) idle keeps everything but the cpu clock
            o_gate.cpu_clk <= (state_next == PMC_RUN);
            // (R8) (R12) internal oscillator halts in Stop and Suspend
            o_gate.int_osc <= (state_next == PMC_RUN || state_next == PMC_IDLE);
            o_gate.dig_periph <= (state_next == PMC_RUN || state_next == PMC_IDLE);
            // (R9) interrupts and timers dark in Stop
            o_gate.irq_timers <= (state_next == PMC_RUN || state_next == PMC_IDLE);
            // (R13) port match survives Suspend
            o_gate.port_match <= (state_next != PMC_STOP);
        end
    end

    // checks
    AST_IDLE_ENTRY: assert property (@(posedge i_clk) disable iff (i_rst) // (R1)
        state_reg == PMC_RUN && idle_arm_reg && !stop_arm_reg && i_instr_done && !rst_req && hold_reg == '0
        |=> state_reg == PMC_IDLE && !o_gate.cpu_clk && o_gate.dig_periph)
        else $error("idle not entered after instruction");
    AST_IDLE_CLOCKS: assert property (@(posedge i_clk) disable iff (i_rst) // (R2)
        $past(state_next) == PMC_IDLE |-> o_gate.int_osc && o_gate.irq_timers)
        else $error("clocks gated in idle");
    AST_IDLE_WAKE: assert property (@(posedge i_clk) disable iff (i_rst) // (R3)
        idle_wake && !rst_req |=> state_reg == PMC_RUN && o_resume && !idle_arm_reg)
        else $error("idle wake failed");
    AST_RESET_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // (R5)
        rst_req |=> o_core_rst && !o_fetch_load && state_reg == PMC_RUN)
        else $error("reset request did not hold the core");
    AST_RESET_VEC: assert property (@(posedge i_clk) disable iff (i_rst) // (R5)
        $fell(rst_req) |-> o_core_rst ##[1:20] o_fetch_load && o_fetch_addr == RESET_VECTOR)
        else $error("reset sequence did not restart fetch");
    AST_WDOG_IDLE: assert property (@(posedge i_clk) disable iff (i_rst) // (R7)
        state_reg == PMC_IDLE && i_wdog_en && i_wdog_expire |=> o_core_rst && state_reg == PMC_RUN)
        else $error("watchdog did not end idle");
    AST_STOP_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // (R10)
        state_reg == PMC_STOP && !rst_req |=> state_reg == PMC_STOP)
        else $error("stop left without reset");
    AST_STOP_GATES: assert property (@(posedge i_clk) disable iff (i_rst) // (R9)
        o_mode == PMC_STOP |-> !o_gate.int_osc && !o_gate.irq_timers && !o_gate.cpu_clk)
        else $error("stop gates wrong");
    AST_SUSP_WAKE: assert property (@(posedge i_clk) disable iff (i_rst) // (R14)
        susp_wake && !rst_req |=> o_resume && o_gate.port_match ##1 o_gate.cpu_clk)
        else $error("suspend wake failed");
    AST_SUSP_PORT: assert property (@(posedge i_clk) disable iff (i_rst) // (R13)
        o_mode == PMC_SUSP |-> o_gate.port_match && !o_gate.dig_periph)
        else $error("suspend peripheral gating wrong");
    AST_READ_ZERO: assert property (@(posedge i_clk) disable iff (i_rst) // (R17)
        o_pwr_rdata[PWR_IDLE_BIT] == 1'b0 && o_pwr_rdata[PWR_STOP_BIT] == 1'b0)
        else $error("select bits read nonzero");
    AST_READ_FLAGS: assert property (@(posedge i_clk) disable iff (i_rst) // (R17)
        $past(i_pwr_wr) |-> o_pwr_rdata == ($past(i_pwr_wdata) & 8'hfc))
        else $error("general flags not read back");
    AST_STOP_PRIO: assert property (@(posedge i_clk) disable iff (i_rst) // (R18)
        state_reg == PMC_RUN && stop_arm_reg && idle_arm_reg && i_instr_done && state_next != PMC_RUN
        |=> state_reg == PMC_STOP)
        else $error("idle beat stop");
    COV_IDLE_IRQ: cover property (@(posedge i_clk) disable iff (i_rst)
        state_reg == PMC_IDLE ##[1:50] o_resume);
    COV_STOP_CLKMON: cover property (@(posedge i_clk) disable iff (i_rst)
        state_reg == PMC_STOP && clkmon_expired);
    COV_SUSP_WAKE_IRQ: cover property (@(posedge i_clk) disable iff (i_rst)
        o_wake_irq);
endmodule

// ---- testbench/pmc_core_model.sv ----
`timescale 1ns/100ps
module pmc_core_model
    import pmc_pkg::*;
(
    // clock
    input wire logic i_clk,
    // restart and resume from the controller
    input wire logic i_fetch_load,
    input wire logic i_resume,
    // register writes and completion
    output logic o_pwr_wr,
    output logic [7:0] o_pwr_wdata,
    output logic o_osc_wr,
    output logic [7:0] o_osc_wdata,
    output logic o_instr_done
);
    int loads = 0;
    int resumes = 0;
    logic ref_bias_en = 1'b0;

    // bus idle until an instruction is issued
    initial begin
        {o_pwr_wr, o_osc_wr, o_instr_done} = 3'h0;
        o_pwr_wdata = 8'h00;
        o_osc_wdata = 8'h00;
    end

    // count restarts and resumes as the core sees them
    always @(posedge i_clk) begin
        if (i_fetch_load)
            loads++;
        if (i_resume)
            resumes++;
    end

    // one write, then the instruction completes g cycles later
    task automatic exec(input logic osc, input logic [7:0] d, input int gap);
        int g;
        g = gap;
        if (!osc && d[PWR_IDLE_BIT] && g < 2)
            g = 2;
        if (osc && d[OSC_SUSPEND_BIT])
            ref_bias_en = 1'b1;
        o_pwr_wr = !osc;
        o_osc_wr = osc;
        o_pwr_wdata = d;
        o_osc_wdata = d;
        @(posedge i_clk);
        #1;
        // stale data is inverted so nothing relies on it
        {o_pwr_wr, o_osc_wr} = 2'b00;
        o_pwr_wdata = ~d;
        o_osc_wdata = ~d;
        repeat (g - 1) begin
            @(posedge i_clk);
            #1;
        end
        o_instr_done = 1'b1;
        @(posedge i_clk);
        #1;
        o_instr_done = 1'b0;
    endtask
endmodule

// ---- testbench/power_mode_controller_tb_top.sv ----
`timescale 1ns/100ps
module power_mode_controller_tb_top
    import pmc_pkg::*;
;
    localparam int HC = 4;
    localparam int MC = 8;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ext_rst_n = 1'b1;
    logic i_irq_pending = 1'b0;
    logic i_wdog_en = 1'b0;
    logic i_wdog_expire = 1'b0;
    logic i_clkmon_en = 1'b0;
    logic i_port_match = 1'b0;
    logic i_cmp_low = 1'b0;
    logic i_cmp_wake_en = 1'b0;
    logic i_wake_irq_en = 1'b0;
    logic pwr_wr, osc_wr, instr_done, o_core_rst, o_fetch_load, o_resume, o_wake_irq;
    logic [7:0] pwr_wd, osc_wd, d, o_pwr_rdata;
    logic [15:0] o_fetch_addr;
    pmc_mode_e o_mode;
    pmc_gate_s o_gate;
    int failures = 0;
    int cmp_count = 0;
    int r;

    // 20 MHz system clock
    always #25 i_clk = ~i_clk;

    pmc_power_mode_ctrl #(.HOLD_CYC(HC), .CLKMON_CYC(MC)) DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_pwr_wr(pwr_wr), .i_pwr_wdata(pwr_wd), .i_osc_wr(osc_wr),
        .i_osc_wdata(osc_wd), .i_instr_done(instr_done), .i_irq_pending(i_irq_pending),
        .i_ext_rst_n(i_ext_rst_n), .i_wdog_en(i_wdog_en), .i_wdog_expire(i_wdog_expire),
        .i_clkmon_en(i_clkmon_en), .i_port_match(i_port_match), .i_cmp_low(i_cmp_low),
        .i_cmp_wake_en(i_cmp_wake_en), .i_wake_irq_en(i_wake_irq_en), .o_pwr_rdata(o_pwr_rdata),
        .o_mode(o_mode), .o_gate(o_gate), .o_core_rst(o_core_rst), .o_fetch_load(o_fetch_load),
        .o_fetch_addr(o_fetch_addr), .o_resume(o_resume), .o_wake_irq(o_wake_irq)
    );

    pmc_core_model core (
        .i_clk(i_clk), .i_fetch_load(o_fetch_load), .i_resume(o_resume), .o_pwr_wr(pwr_wr),
        .o_pwr_wdata(pwr_wd), .o_osc_wr(osc_wr), .o_osc_wdata(osc_wd), .o_instr_done(instr_done)
    );

    // expected gate enables per mode
    function automatic pmc_gate_s gexp(pmc_mode_e m);
        case (m)
            PMC_IDLE: return 5'b01111;
            PMC_STOP: return 5'b00000;
            PMC_SUSP: return 5'b00001;
            default: return 5'b11111;
        endcase
    endfunction

    task automatic step();
        @(posedge i_clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // bounded waits on mode, resume pulse and restart
    task automatic wmode(input pmc_mode_e m, input int lim);
        int k;
        k = 0;
        while (o_mode !== m && k++ < lim)
            step();
        chk(16'(o_mode), 16'(m), "mode");
    endtask

    task automatic wres(input int lim);
        int k;
        k = 0;
        while (o_resume !== 1'b1 && k++ < lim)
            step();
        chk(16'(o_resume), 16'h0001, "resume");
    endtask

    task automatic wload(input int lim);
        int b, k;
        b = core.loads;
        k = 0;
        while (core.loads == b && k++ < lim)
            step();
        chk(16'(core.loads - b), 16'h0001, "restart");
        chk(o_fetch_addr, RESET_VECTOR, "fetch address");
        chk(16'(o_core_rst), 16'h0000, "core released");
        chk(16'(o_mode), 16'(PMC_RUN), "mode after reset");
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // cut a hang short; the tests need under two hundred cycles
    initial begin
        repeat (3000) @(posedge i_clk);
        failures++;
        results();
    end

    initial begin
        void'($urandom(32'h555d177f));
        repeat (10) @(posedge i_clk);
        #1;
        chk(16'(o_core_rst), 16'h0001, "core held");
        i_rst = 1'b0;
        wload(HC + 4);
        $display("test reset done");
        // idle with random flags, woken by an interrupt
        for (int n = 0; n < 4; n++) begin
            d = {6'($urandom), 2'b01};
            core.exec(1'b0, d, int'(1 + $urandom % 3));
            chk(16'(o_pwr_rdata), {8'h00, d[7:2], 2'b00}, "read back");
            wmode(PMC_IDLE, 3);
            chk(16'(o_gate), 16'(gexp(PMC_IDLE)), "idle gates");
            repeat ($urandom % 6) step();
            r = core.resumes;
            i_irq_pending = 1'b1;
            wres(3);
            chk(16'(o_mode), 16'(PMC_RUN), "idle wake");
            step();
            i_irq_pending = 1'b0;
            chk(16'(core.resumes - r), 16'h0001, "resume count");
        end
        $display("test idle done");
        // watchdog ends idle only while enabled
        core.exec(1'b0, 8'h01, 2);
        wmode(PMC_IDLE, 3);
        i_wdog_expire = 1'b1;
        step();
        i_wdog_expire = 1'b0;
        repeat (3) step();
        chk(16'(o_mode), 16'(PMC_IDLE), "disabled watchdog");
        {i_wdog_en, i_wdog_expire} = 2'b11;
        step();
        i_wdog_expire = 1'b0;
        wload(HC + 6);
        i_wdog_en = 1'b0;
        $display("test watchdog done");
        // stop, also with idle select set; only a reset ends it
        for (int n = 0; n < 2; n++) begin
            d = {6'($urandom), 1'b1, 1'(n)};
            core.exec(1'b0, d, int'(1 + $urandom % 3));
            wmode(PMC_STOP, 3);
            chk(16'(o_gate), 16'(gexp(PMC_STOP)), "stop gates");
            i_irq_pending = 1'b1;
            repeat (5) step();
            i_irq_pending = 1'b0;
            chk(16'(o_mode), 16'(PMC_STOP), "irq ended stop");
            if (n == 0) begin
                i_ext_rst_n = 1'b0;
                repeat (3) step();
                i_ext_rst_n = 1'b1;
                wload(HC + 8);
            end else begin
                i_clkmon_en = 1'b1;
                repeat (MC - 2) step();
                chk(16'(o_mode), 16'(PMC_STOP), "early detector");
                wload(HC + 12);
                i_clkmon_en = 1'b0;
            end
        end
        $display("test stop done");
        // suspend woken by port match or enabled comparator
        for (int n = 0; n < 4; n++) begin
            i_wake_irq_en = n[1];
            d = {2'($urandom), 1'b1, 5'($urandom)};
            core.exec(1'b1, d, int'(1 + $urandom % 3));
            wmode(PMC_SUSP, 3);
            chk(16'(core.ref_bias_en), 16'h0001, "bias enable");
            chk(16'(o_gate), 16'(gexp(PMC_SUSP)), "suspend gates");
            i_cmp_low = 1'b1;
            repeat (5) step();
            chk(16'(o_mode), 16'(PMC_SUSP), "comparator not enabled");
            i_cmp_wake_en = n[0];
            i_port_match = !n[0];
            wres(6);
            chk(16'(o_wake_irq), 16'(n[1]), "wake interrupt");
            {i_cmp_low, i_cmp_wake_en, i_port_match} = 3'b000;
            repeat (4) step();
        end
        $display("test suspend done");
        results();
    end
endmodule
